// ===== hw/tmon_pkg.sv
// constants, types and the address map of the smbus thermal monitor
// assumes one 40 MHz clock; the analog front end lives outside this block
package tmon_pkg;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned CONV_SLOWEST_S = 16; // 0.0625 conversions per second
	localparam int unsigned CONV_BASE_CYC = CONV_SLOWEST_S * CLK_HZ;
	localparam int unsigned TIMEOUT_MS = 25;
	localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
	// ---------------------------------------------------------------
	// slave addresses
	// ---------------------------------------------------------------
	localparam logic [6:0] ADDR_7K5 = 7'h48;
	localparam logic [6:0] ADDR_12K = 7'h49;
	localparam logic [6:0] ADDR_20K = 7'h38;
	localparam logic [6:0] ADDR_33K = 7'h39;
	localparam logic [6:0] ADDR_ALT_BIT = 7'h02;
	localparam logic [6:0] ADDR_ALERT_RESP = 7'h0c;
	// ---------------------------------------------------------------
	// register pointers and reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_TEMP_HI = 8'h00;
	localparam logic [7:0] REG_TEMP_LO = 8'h01;
	localparam logic [7:0] REG_STATUS = 8'h02;
	localparam logic [7:0] REG_CONFIG = 8'h03;
	localparam logic [7:0] REG_RATE = 8'h04;
	localparam logic [7:0] REG_HIGH_LIM = 8'h05;
	localparam logic [7:0] REG_LOW_LIM = 8'h06;
	localparam logic [7:0] REG_ONE_SHOT = 8'h0f;
	localparam logic [7:0] REG_OVERTEMP_THERMOSTAT_OUT_LIM = 8'h20;
	localparam logic [7:0] REG_OVERTEMP_THERMOSTAT_OUT_HYS = 8'h21;
	localparam logic [7:0] REG_TIMEOUT = 8'h22;
	localparam int CFG_MASK_BIT = 7;
	localparam int CFG_STBY_BIT = 6;
	localparam int CFG_MODE_BIT = 5;
	localparam int TMO_EN_BIT = 7;
	localparam logic [7:0] RST_CONFIG = 8'h00;
	localparam logic [2:0] RST_RATE = 3'h4;
	localparam logic [7:0] RST_HIGH_LIM = 8'h55;
	localparam logic [7:0] RST_LOW_LIM = 8'h00;
	localparam logic [7:0] RST_OVERTEMP_THERMOSTAT_OUT_LIM = 8'h55;
	localparam logic [7:0] RST_OVERTEMP_THERMOSTAT_OUT_HYS = 8'h0a;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [1:0] BYTE_ADDR = 2'h0;
	localparam logic [1:0] BYTE_CMD = 2'h1;
	localparam logic [1:0] BYTE_DATA = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX = 3'b001,
		ST_ACK = 3'b010,
		ST_TX = 3'b011,
		ST_TXACK = 3'b100,
		ST_WAIT = 3'b101
	} tmon_state_e;

	// open-drain pin: out is always low, oe pulls the wire
	typedef struct packed {
		logic out;
		logic oe;
	} tmon_od_s;

	function automatic logic [6:0] tmon_addr_map(input logic [1:0] sense, input logic alt);
		logic [6:0] a;
		case (sense)
			2'h0: a = ADDR_7K5;
			2'h1: a = ADDR_12K;
			2'h2: a = ADDR_20K;
			default: a = ADDR_33K;
		endcase
		return alt ? (a | ADDR_ALT_BIT) : a;
	endfunction
endpackage

// ===== hw/tmon_top.sv
// smbus slave thermal monitor: address strap, conversion pacing,
// thermostat, window alert and open-drain pin drive
// assumes pins already synchronous to mclk; analog converter outside
// What this block does
// - the address strap is sampled once after reset and the address then holds.
// - base variant maps the four strap codes to 48h, 49h, 38h, 39h.
// - alternate variant maps them to 4ah, 4bh, 3ah, 3bh.
// - thermostat asserts at the threshold and clears below threshold minus hysteresis.
// - alert pin is either a maskable window alert or a second thermostat, open-drain.
// - the address pin doubles as the open-drain overtemperature output.
// - standby stops periodic conversions; a one-shot written in standby runs exactly one conversion, in run mode none.
// - in run mode conversions repeat at a programmable rate down to one per 16 s.
// - in alert mode an alert is shown on the alert pin; in both modes it is served by the host via the alert response address.
// - wrong address gets no acknowledge and changes no register; a longer write gets no acknowledge from its second data byte on, after the first is written.
// - with timeout enabled an idle transaction is abandoned after about 25 ms.
// - result is 10-bit two's complement, top eight bits high byte, two bits low byte.
// - only write byte, read byte, send byte, receive byte and alert response are served.
`timescale 1ns/1ps
module tmon_top import tmon_pkg::*; #(
	parameter bit ALT_VARIANT = 1'b0,
	parameter int unsigned CONV_CYC = CONV_BASE_CYC,
	parameter int unsigned TMO_CYC = TIMEOUT_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic serial_bus_clock_pin,
	input wire logic serial_bus_data_pin_in,
	output tmon_od_s serial_bus_data_pin,
	output tmon_od_s address_select_overtemp_pin,
	output tmon_od_s alert_or_second_thermostat_pin,
	input wire logic [1:0] addr_sense,
	output logic conv_start,
	input wire logic conv_done,
	input wire logic [9:0] conv_result,
	output logic overtemp_thermostat_out
);
	// ---------------------------------------------------------------
	// bus state
	// ---------------------------------------------------------------
	tmon_state_e st_r, st_nxt;
	logic scl_q_r, sda_q_r, oe_r, oe_nxt, rw_r, rw_nxt, ara_r, ara_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [1:0] byte_r, byte_nxt;
	logic [7:0] sh_r, sh_nxt, rdata;
	logic [19:0] tmo_r, tmo_nxt;
	logic scl_rise, scl_fall, start_c, stop_c, tmo_fire, decide, ptr_wr, reg_wr, ara_done;
	// register and conversion state
	logic strap_r, strap_nxt, tmo_en_r, tmo_en_nxt;
	logic [6:0] own_r, own_nxt;
	logic [7:0] ptr_r, ptr_nxt, cfg_r, cfg_nxt, hi_r, hi_nxt, lo_r, lo_nxt;
	logic [7:0] tlim_r, tlim_nxt, thys_r, thys_nxt;
	logic [2:0] rate_r, rate_nxt;
	logic [9:0] temp_r, temp_nxt;
	logic [29:0] tick_r, tick_nxt;
	logic busy_r, busy_nxt, due_r, due_nxt, shot_r, shot_nxt, start_r, start_nxt;
	logic overtemp_thermostat_out_r, overtemp_thermostat_out_nxt, therm2_r, therm2_nxt, alert_r, alert_nxt;
	logic signed [9:0] t_new, tlim_s, tclr_s, hlim_s, hclr_s, low_s;
	logic standby, out_win;

	assign scl_rise = serial_bus_clock_pin & ~scl_q_r;
	assign scl_fall = ~serial_bus_clock_pin & scl_q_r;
	assign start_c = serial_bus_clock_pin & scl_q_r & sda_q_r & ~serial_bus_data_pin_in;
	assign stop_c = serial_bus_clock_pin & scl_q_r & ~sda_q_r & serial_bus_data_pin_in;
	assign tmo_fire = tmo_en_r && (st_r != ST_IDLE) && (tmo_r >= 20'(TMO_CYC - 1));
	assign decide = (st_r == ST_RX) && scl_fall && (bit_r == BITS_PER_BYTE);
	assign ptr_wr = decide && !rw_r && (byte_r == BYTE_CMD);
	assign reg_wr = decide && !rw_r && (byte_r == BYTE_DATA);
	assign ara_done = (st_r == ST_TXACK) && scl_rise && ara_r;

	// ---------------------------------------------------------------
	// smbus slave engine
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		oe_nxt = oe_r;
		rw_nxt = rw_r;
		ara_nxt = ara_r;
		bit_nxt = bit_r;
		byte_nxt = byte_r;
		sh_nxt = sh_r;
		// inactivity means no clock edge and no start or stop condition
		tmo_nxt = (scl_rise || scl_fall || start_c || stop_c || st_r == ST_IDLE) ? 20'h0 :
			tmo_r + 20'h1;
		if (start_c) begin
			st_nxt = ST_RX;
			oe_nxt = 1'b0;
			bit_nxt = 4'h0;
			byte_nxt = BYTE_ADDR;
			ara_nxt = 1'b0;
		end else if (stop_c || tmo_fire) begin
			st_nxt = ST_IDLE;
			oe_nxt = 1'b0;
		end else begin
			case (st_r)
				ST_RX: begin
					if (scl_rise) begin
						sh_nxt = {sh_r[6:0], serial_bus_data_pin_in};
						bit_nxt = bit_r + 4'h1;
					end
					if (decide) begin
						st_nxt = ST_ACK;
						oe_nxt = 1'b1;
						bit_nxt = 4'h0;
						byte_nxt = byte_r + 2'h1;
						if (byte_r == BYTE_ADDR) begin
							rw_nxt = sh_r[0];
							if (sh_r[7:1] == own_r) begin
								ara_nxt = 1'b0;
							end else if (sh_r[7:1] == ADDR_ALERT_RESP && sh_r[0] && alert_r) begin
								ara_nxt = 1'b1;
							end else begin
								st_nxt = ST_WAIT;
								oe_nxt = 1'b0;
							end
						end else if (rw_r || byte_r > BYTE_DATA) begin
							st_nxt = ST_WAIT;
							oe_nxt = 1'b0;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (rw_r) begin
							sh_nxt = ara_r ? {own_r, 1'b1} : rdata;
							oe_nxt = ara_r ? ~own_r[6] : ~rdata[7];
							bit_nxt = 4'h1;
							st_nxt = ST_TX;
						end else begin
							oe_nxt = 1'b0;
							st_nxt = ST_RX;
						end
					end
				end
				ST_TX: begin
					// sent a 1 but the wire reads 0: another slave won, keep off the bus
					if (scl_rise && !oe_r && !serial_bus_data_pin_in) begin
						st_nxt = ST_WAIT;
					end else if (scl_fall) begin
						if (bit_r == BITS_PER_BYTE) begin
							oe_nxt = 1'b0;
							st_nxt = ST_TXACK;
						end else begin
							sh_nxt = {sh_r[6:0], 1'b0};
							oe_nxt = ~sh_r[6];
							bit_nxt = bit_r + 4'h1;
						end
					end
				end
				ST_TXACK: begin
					// only single-byte reads exist, so any answer ends it
					if (scl_rise) begin
						st_nxt = ST_WAIT;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_r <= ST_IDLE;
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
			oe_r <= 1'b0;
			rw_r <= 1'b0;
			ara_r <= 1'b0;
			bit_r <= 4'h0;
			byte_r <= BYTE_ADDR;
			sh_r <= 8'h00;
			tmo_r <= 20'h0;
		end else begin
			st_r <= st_nxt;
			scl_q_r <= serial_bus_clock_pin;
			sda_q_r <= serial_bus_data_pin_in;
			oe_r <= oe_nxt;
			rw_r <= rw_nxt;
			ara_r <= ara_nxt;
			bit_r <= bit_nxt;
			byte_r <= byte_nxt;
			sh_r <= sh_nxt;
			tmo_r <= tmo_nxt;
		end
	end

	// ---------------------------------------------------------------
	// registers reached over the bus
	// ---------------------------------------------------------------
	always_comb begin
		case (ptr_r)
			REG_TEMP_HI: rdata = temp_r[9:2];
			REG_TEMP_LO: rdata = {temp_r[1:0], 6'h00};
			REG_STATUS: rdata = {busy_r, overtemp_thermostat_out_r, therm2_r, alert_r, 4'h0};
			REG_CONFIG: rdata = cfg_r;
			REG_RATE: rdata = {5'h00, rate_r};
			REG_HIGH_LIM: rdata = hi_r;
			REG_LOW_LIM: rdata = lo_r;
			REG_OVERTEMP_THERMOSTAT_OUT_LIM: rdata = tlim_r;
			REG_OVERTEMP_THERMOSTAT_OUT_HYS: rdata = thys_r;
			REG_TIMEOUT: rdata = {tmo_en_r, 7'h00};
			default: rdata = 8'h00;
		endcase
	end

	always_comb begin
		strap_nxt = 1'b1;
		own_nxt = strap_r ? own_r : tmon_addr_map(addr_sense, ALT_VARIANT);
		ptr_nxt = ptr_wr ? sh_r : ptr_r;
		cfg_nxt = (reg_wr && ptr_r == REG_CONFIG) ? sh_r : cfg_r;
		rate_nxt = (reg_wr && ptr_r == REG_RATE) ? sh_r[2:0] : rate_r;
		hi_nxt = (reg_wr && ptr_r == REG_HIGH_LIM) ? sh_r : hi_r;
		lo_nxt = (reg_wr && ptr_r == REG_LOW_LIM) ? sh_r : lo_r;
		tlim_nxt = (reg_wr && ptr_r == REG_OVERTEMP_THERMOSTAT_OUT_LIM) ? sh_r : tlim_r;
		thys_nxt = (reg_wr && ptr_r == REG_OVERTEMP_THERMOSTAT_OUT_HYS) ? sh_r : thys_r;
		tmo_en_nxt = (reg_wr && ptr_r == REG_TIMEOUT) ? sh_r[TMO_EN_BIT] : tmo_en_r;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			strap_r <= 1'b0;
			own_r <= ADDR_7K5;
			ptr_r <= REG_TEMP_HI;
			cfg_r <= RST_CONFIG;
			rate_r <= RST_RATE;
			hi_r <= RST_HIGH_LIM;
			lo_r <= RST_LOW_LIM;
			tlim_r <= RST_OVERTEMP_THERMOSTAT_OUT_LIM;
			thys_r <= RST_OVERTEMP_THERMOSTAT_OUT_HYS;
			tmo_en_r <= 1'b0;
		end else begin
			strap_r <= strap_nxt;
			own_r <= own_nxt;
			ptr_r <= ptr_nxt;
			cfg_r <= cfg_nxt;
			rate_r <= rate_nxt;
			hi_r <= hi_nxt;
			lo_r <= lo_nxt;
			tlim_r <= tlim_nxt;
			thys_r <= thys_nxt;
			tmo_en_r <= tmo_en_nxt;
		end
	end

	// ---------------------------------------------------------------
	// conversion pacing, thermostats and alert
	// ---------------------------------------------------------------
	assign standby = cfg_r[CFG_STBY_BIT];
	// limits compare against the high byte, widened so hysteresis cannot wrap
	assign t_new = 10'(signed'(conv_result[9:2]));
	assign tlim_s = 10'(signed'(tlim_r));
	assign tclr_s = tlim_s - signed'({2'b00, thys_r});
	assign hlim_s = 10'(signed'(hi_r));
	assign hclr_s = hlim_s - signed'({2'b00, thys_r});
	assign low_s = 10'(signed'(lo_r));
	assign out_win = (t_new > hlim_s) || (t_new < low_s);

	always_comb begin
		tick_nxt = tick_r;
		due_nxt = due_r;
		if (standby) begin
			tick_nxt = 30'h0;
			due_nxt = 1'b0;
		end else if (tick_r >= (30'(CONV_CYC) >> rate_r) - 30'h1) begin
			tick_nxt = 30'h0;
			due_nxt = 1'b1;
		end else begin
			tick_nxt = tick_r + 30'h1;
		end
		shot_nxt = shot_r || (reg_wr && ptr_r == REG_ONE_SHOT && standby);
		start_nxt = 1'b0;
		busy_nxt = busy_r;
		if (busy_r) begin
			busy_nxt = !conv_done;
		end else if (due_r || shot_r) begin
			start_nxt = 1'b1;
			busy_nxt = 1'b1;
			due_nxt = 1'b0;
			shot_nxt = reg_wr && ptr_r == REG_ONE_SHOT && standby; // a new command is kept
		end
		temp_nxt = (busy_r && conv_done) ? conv_result : temp_r;
		overtemp_thermostat_out_nxt = overtemp_thermostat_out_r;
		therm2_nxt = therm2_r;
		alert_nxt = alert_r && !ara_done;
		if (busy_r && conv_done) begin
			if (t_new >= tlim_s) begin
				overtemp_thermostat_out_nxt = 1'b1;
			end else if (t_new < tclr_s) begin
				overtemp_thermostat_out_nxt = 1'b0;
			end
			if (t_new >= hlim_s) begin
				therm2_nxt = 1'b1;
			end else if (t_new < hclr_s) begin
				therm2_nxt = 1'b0;
			end
			// a new event beats a same-cycle clear from the alert response
			if (out_win && !cfg_r[CFG_MASK_BIT]) begin
				alert_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tick_r <= 30'h0;
			due_r <= 1'b0;
			shot_r <= 1'b0;
			start_r <= 1'b0;
			busy_r <= 1'b0;
			temp_r <= 10'h000;
			overtemp_thermostat_out_r <= 1'b0;
			therm2_r <= 1'b0;
			alert_r <= 1'b0;
		end else begin
			tick_r <= tick_nxt;
			due_r <= due_nxt;
			shot_r <= shot_nxt;
			start_r <= start_nxt;
			busy_r <= busy_nxt;
			temp_r <= temp_nxt;
			overtemp_thermostat_out_r <= overtemp_thermostat_out_nxt;
			therm2_r <= therm2_nxt;
			alert_r <= alert_nxt;
		end
	end

	// ---------------------------------------------------------------
	// pins: every open-drain output only ever pulls low
	// ---------------------------------------------------------------
	assign conv_start = start_r;
	assign overtemp_thermostat_out = overtemp_thermostat_out_r;
	assign serial_bus_data_pin = '{out: 1'b0, oe: oe_r};
	assign address_select_overtemp_pin = '{out: 1'b0, oe: overtemp_thermostat_out_r};
	assign alert_or_second_thermostat_pin = '{out: 1'b0,
		oe: cfg_r[CFG_MODE_BIT] ? therm2_r : alert_r};

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	addr_hold_a: assert property (@(posedge mclk) disable iff (rst) strap_r |=> $stable(own_r))
		else $error("slave address changed after strap");
	addr_base_a: assert property (@(posedge mclk) disable iff (rst)
		(!ALT_VARIANT && !strap_r && addr_sense == 2'h2) |=> own_r == ADDR_20K)
		else $error("base address map wrong");
	addr_alt_a: assert property (@(posedge mclk) disable iff (rst)
		(ALT_VARIANT && !strap_r && addr_sense == 2'h1) |=> own_r == (ADDR_12K | ADDR_ALT_BIT))
		else $error("alternate address map wrong");
	overtemp_thermostat_out_trip_a: assert property (@(posedge mclk) disable iff (rst)
		(busy_r && conv_done && t_new >= tlim_s) |=> overtemp_thermostat_out_r ##0 address_select_overtemp_pin.oe)
		else $error("thermostat did not trip");
	overtemp_thermostat_out_keep_a: assert property (@(posedge mclk) disable iff (rst)
		(overtemp_thermostat_out_r && !(busy_r && conv_done && t_new < tclr_s)) |=> overtemp_thermostat_out_r)
		else $error("thermostat released inside hysteresis");
	alert_raise_a: assert property (@(posedge mclk) disable iff (rst)
		(busy_r && conv_done && out_win && !cfg_r[CFG_MASK_BIT] && !cfg_r[CFG_MODE_BIT]
		&& !reg_wr) |=> alert_or_second_thermostat_pin.oe)
		else $error("window alert not raised");
	standby_quiet_a: assert property (@(posedge mclk) disable iff (rst)
		(standby && !shot_r && !due_r && !reg_wr) |=> !conv_start)
		else $error("conversion started in standby");
	nack_foreign_a: assert property (@(posedge mclk) disable iff (rst)
		(decide && byte_r == BYTE_ADDR && sh_r[7:1] != own_r && sh_r[7:1] != ADDR_ALERT_RESP
		&& !start_c) |=> !serial_bus_data_pin.oe [*2])
		else $error("acknowledged a foreign address");
	bus_timeout_a: assert property (@(posedge mclk) disable iff (rst)
		(tmo_fire && !start_c) |=> st_r == ST_IDLE && !serial_bus_data_pin.oe)
		else $error("timeout did not release bus");
	low_byte_a: assert property (@(posedge mclk) disable iff (rst)
		ptr_r == REG_TEMP_LO |-> rdata[5:0] == 6'h00 && rdata[7:6] == temp_r[1:0])
		else $error("low temperature byte malformed");
endmodule

// ===== bench/tmon_host.sv
// smbus host model: start, stop, byte and protocol tasks
// assumes the bench resolves the data wire with a pull-up; clock phases of PH mclk cycles
`timescale 1ns/1ps
module tmon_host import tmon_pkg::*; #(
	parameter int PH = 4
) (
	input wire logic mclk,
	input wire logic sda_in,
	output logic scl,
	output logic sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic edge_wait(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// also serves as repeated start; leaves the clock low
	task automatic start_cond();
		sda_low <= 1'b0;
		edge_wait(PH);
		scl <= 1'b1;
		edge_wait(PH);
		sda_low <= 1'b1;
		edge_wait(PH);
		scl <= 1'b0;
		edge_wait(PH);
	endtask
	task automatic stop_cond();
		sda_low <= 1'b1;
		edge_wait(PH);
		scl <= 1'b1;
		edge_wait(PH);
		sda_low <= 1'b0;
		edge_wait(2 * PH);
	endtask
	// eight bits then the ninth; a 1 releases the wire so the slave can answer
	task automatic xfer(input logic [7:0] tx, input logic nine, output logic [7:0] rx,
		output logic ack);
		for (int i = 8; i >= 0; i--) begin
			sda_low <= (i > 0) ? ~tx[i - 1] : ~nine;
			edge_wait(PH);
			scl <= 1'b1;
			edge_wait(PH);
			if (i > 0) begin
				rx[i - 1] = sda_in;
			end else begin
				ack = sda_in;
			end
			scl <= 1'b0;
			edge_wait(PH);
		end
	endtask
	// only three of the supported frame kinds are issued by these tasks: write byte, read byte, alert response
	task automatic write_reg(input logic [6:0] a, input logic [7:0] c, input logic [7:0] v,
		output logic ok);
		logic [7:0] rx;
		logic k0;
		logic k1;
		logic k2;
		start_cond();
		xfer({a, 1'b0}, 1'b1, rx, k0);
		xfer(c, 1'b1, rx, k1);
		xfer(v, 1'b1, rx, k2);
		stop_cond();
		ok = ~(k0 | k1 | k2);
	endtask
	task automatic read_reg(input logic [6:0] a, input logic [7:0] c, output logic [7:0] d,
		output logic ok);
		logic k0;
		logic k1;
		logic k2;
		logic nk;
		start_cond();
		xfer({a, 1'b0}, 1'b1, d, k0);
		xfer(c, 1'b1, d, k1);
		start_cond();
		xfer({a, 1'b1}, 1'b1, d, k2);
		xfer(8'hff, 1'b1, d, nk);
		stop_cond();
		ok = ~(k0 | k1 | k2);
	endtask
	// an asserted alert is served by polling the alert response address
	task automatic alert_poll(output logic [7:0] d, output logic ok);
		logic k0;
		logic nk;
		start_cond();
		xfer({ADDR_ALERT_RESP, 1'b1}, 1'b1, d, k0);
		xfer(8'hff, 1'b1, d, nk);
		stop_cond();
		ok = ~k0;
	endtask
endmodule

// ===== bench/test_smbus_thermal_monitor.sv
// bench: one part of each variant on a shared bus, driven by the host model
// assumes short conversion and timeout counts; converter answers four cycles after start
`timescale 1ns/1ps
module test_smbus_thermal_monitor import tmon_pkg::*; ;
	logic mclk;
	logic rst;
	logic [1:0] addr_sense;
	logic [9:0] conv_result;
	logic start_a;
	logic start_b;
	logic done_a = 1'b0;
	logic done_b = 1'b0;
	logic [2:0] sh_a = 3'h0;
	logic [2:0] sh_b = 3'h0;
	logic overtemp_thermostat_out_a;
	logic scl;
	logic sda_low;
	tmon_od_s sda_a;
	tmon_od_s sda_b;
	tmon_od_s pin_a;
	tmon_od_s pin_b;
	tmon_od_s al_a;
	tmon_od_s al_b;
	wire logic sda_wire;
	int errors;
	int comparisons;
	int starts = 0;
	logic ok;
	logic [7:0] d;
	// pull-up on the data wire; any party may pull it low
	assign sda_wire = ~(sda_low | sda_a.oe | sda_b.oe);
	tmon_top #(.CONV_CYC(64), .TMO_CYC(200)) i_tmon_top (
		.mclk(mclk), .rst(rst), .serial_bus_clock_pin(scl), .serial_bus_data_pin_in(sda_wire),
		.serial_bus_data_pin(sda_a), .address_select_overtemp_pin(pin_a),
		.alert_or_second_thermostat_pin(al_a), .addr_sense(addr_sense), .conv_start(start_a),
		.conv_done(done_a), .conv_result(conv_result), .overtemp_thermostat_out(overtemp_thermostat_out_a));
	tmon_top #(.ALT_VARIANT(1'b1), .CONV_CYC(64), .TMO_CYC(200)) i_tmon_top_alt (
		.mclk(mclk), .rst(rst), .serial_bus_clock_pin(scl), .serial_bus_data_pin_in(sda_wire),
		.serial_bus_data_pin(sda_b), .address_select_overtemp_pin(pin_b),
		.alert_or_second_thermostat_pin(al_b), .addr_sense(addr_sense), .conv_start(start_b),
		.conv_done(done_b), .conv_result(conv_result), .overtemp_thermostat_out());
	tmon_host i_tmon_host (.mclk(mclk), .sda_in(sda_wire), .scl(scl), .sda_low(sda_low));
	initial begin
		mclk = 1'b0;
		forever begin
			#12.5;
			mclk = ~mclk;
		end
	end
	always @(posedge mclk) begin
		sh_a <= {sh_a[1:0], start_a};
		sh_b <= {sh_b[1:0], start_b};
		done_a <= sh_a[2];
		done_b <= sh_b[2];
		if (start_a === 1'b1) starts <= starts + 1;
	end
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic finish_test();
		if (errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic do_reset(input logic [1:0] code);
		rst <= 1'b1;
		addr_sense <= code;
		repeat (6) @(posedge mclk);
		check("pins in reset", {5'h00, pin_a.oe, al_a.oe, sda_a.oe}, 8'h00);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] v);
		i_tmon_host.write_reg(a, c, v, ok);
		check("write ack", {7'h00, ok}, 8'h01);
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] c);
		i_tmon_host.read_reg(a, c, d, ok);
		check("read ack", {7'h00, ok}, 8'h01);
	endtask
	// two completed conversions guarantee the newest input was taken
	task automatic set_temp(input logic [7:0] hb);
		int n;
		n = 0;
		conv_result <= {hb, 2'b00};
		for (int i = 0; i < 2000 && n < 2; i++) begin
			@(posedge mclk);
			if (done_a === 1'b1) n++;
		end
		if (n < 2) begin
			errors++;
			$display("Error conversion wait expected 2 seen %0d", n);
			finish_test();
		end
		repeat (2) @(posedge mclk);
	endtask
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_strap();
		logic [6:0] base [4] = '{7'h48, 7'h49, 7'h38, 7'h39};
		for (int i = 0; i < 4; i++) begin
			do_reset(2'(i));
			rd(base[i], REG_HIGH_LIM);
			check("base variant address", d, 8'h55);
			rd(base[i] | 7'h02, REG_HIGH_LIM);
			check("alt variant address", d, 8'h55);
		end
		do_reset(2'h0);
		addr_sense <= 2'h3;
		i_tmon_host.write_reg(7'h4c, REG_HIGH_LIM, 8'h11, ok);
		check("foreign address ack", {7'h00, ok}, 8'h00);
		rd(7'h48, REG_HIGH_LIM);
		check("address held", d, 8'h55);
	endtask
	task automatic t_temp();
		set_temp(8'h31);
		conv_result <= 10'h0c7;
		repeat (40) @(posedge mclk);
		rd(7'h48, REG_TEMP_HI);
		check("temp high byte", d, 8'h31);
		rd(7'h48, REG_TEMP_LO);
		check("temp low byte", d, 8'hc0);
	endtask
	task automatic t_overtemp_thermostat_out();
		set_temp(8'h56);
		check("thermostat set", {6'h00, overtemp_thermostat_out_a, pin_a.oe}, 8'h03);
		set_temp(8'h4c);
		check("thermostat hysteresis", {6'h00, overtemp_thermostat_out_a, pin_a.oe}, 8'h03);
		set_temp(8'h4a);
		check("thermostat cleared", {6'h00, overtemp_thermostat_out_a, pin_a.oe}, 8'h00);
	endtask
	task automatic t_alert();
		check("alert latched", {6'h00, al_a.oe, al_b.oe}, 8'h03);
		i_tmon_host.alert_poll(d, ok);
		check("alert response base", d, 8'h91);
		check("alert after poll", {6'h00, al_a.oe, al_b.oe}, 8'h01);
		i_tmon_host.alert_poll(d, ok);
		check("alert response alt", d, 8'h95);
		wr(7'h48, REG_CONFIG, 8'h80);
		set_temp(8'h60);
		check("masked alert", {7'h00, al_a.oe}, 8'h00);
		wr(7'h48, REG_CONFIG, 8'h20);
		check("second thermostat set", {7'h00, al_a.oe}, 8'h01);
		set_temp(8'h4a);
		check("second thermostat clear", {7'h00, al_a.oe}, 8'h00);
		wr(7'h48, REG_CONFIG, 8'h00);
		check("alert pin shows latch", {7'h00, al_a.oe}, 8'h01);
	endtask
	task automatic t_rate();
		int n;
		wr(7'h48, REG_CONFIG, 8'h40);
		n = starts;
		repeat (300) @(posedge mclk);
		check("standby starts", 8'(starts - n), 8'h00);
		n = starts;
		wr(7'h48, REG_ONE_SHOT, 8'h01);
		repeat (300) @(posedge mclk);
		check("one-shot starts", 8'(starts - n), 8'h01);
		wr(7'h48, REG_CONFIG, 8'h00);
		// phase of the pacing tick is free, so allow one start either way
		for (int r = 0; r < 3; r += 2) begin
			wr(7'h48, REG_RATE, 8'(r));
			n = starts;
			repeat (640) @(posedge mclk);
			n = starts - n;
			check("run rate", {7'h00, n inside {[(10 << r) - 1:(10 << r) + 1]}}, 8'h01);
		end
	endtask
	task automatic t_timeout();
		logic [7:0] rx;
		logic k;
		wr(7'h48, REG_TIMEOUT, 8'h80);
		i_tmon_host.start_cond();
		i_tmon_host.xfer({7'h48, 1'b0}, 1'b1, rx, k);
		i_tmon_host.xfer(REG_LOW_LIM, 1'b1, rx, k);
		i_tmon_host.stop_cond();
		i_tmon_host.start_cond();
		i_tmon_host.xfer({7'h48, 1'b1}, 1'b1, rx, k);
		check("read bit driven", {7'h00, sda_a.oe}, 8'h01);
		repeat (260) @(posedge mclk);
		check("timeout release", {7'h00, sda_a.oe}, 8'h00);
		i_tmon_host.stop_cond();
		rd(7'h48, REG_TIMEOUT);
		check("timeout enable", d, 8'h80);
	endtask
	initial begin
		errors = 0;
		comparisons = 0;
		rst = 1'b1;
		addr_sense = 2'h0;
		conv_result = 10'h000;
		t_strap();
		t_temp();
		t_overtemp_thermostat_out();
		t_alert();
		t_rate();
		t_timeout();
		finish_test();
	end
endmodule
